// *** rtl/spi_fault_diag_command_logic.sv ***
// serial command decoder and fault diagnosis reporting
// Functional notes
// - latched motor overcurrent: set flag, stop drivers, fault and reset high.
// - thermal shutdown: set flag, stop drivers, fault and reset high.
// - logic overvoltage, crc, transceiver, frame error: flag, fault low.
// - reset output low clears motor overcurrent flag, drivers off.
// - detect enable low holds motor overcurrent flag clear, drivers enabled.
// - six top frame bits are the command code.
// - mode command: bit 7 sample hold, bit 6 short calibration, default 0.
// - gain command: bits 7:6 select gain x1 to x4, x1 default.
// - codes 000011 and 011000 accepted but change nothing.
// - 001000 returns first diagnosis, 010000 returns second diagnosis.
// - undefined command code sets frame error flag.
// - first reply: header 15:8, eight fail flags in 7:0.
// - second reply: frame error flag in bit 7.
// - each diagnosis set clears once it has been read.
// - events during transfer go to shadow, moved after shift out.
// - fault output driven by a diagnosis flag stays asserted until new diagnosis has been read.
// - first diagnosis snapshot at chip select fall; later events next read.
// - frame is 16 clocks msb first; update only on correct count.
`timescale 1ns/1ns
`include "fault_diag_params.svh"

module spi_fault_diag_command_logic (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // serial port pins
  input  wire logic                  cs_n,
  input  wire logic                  sck,
  input  wire logic                  din,
  output logic                       dout,
  output logic                       dout_oe,
  // fault sources, level high while present, and enables
  input  wire logic                  supply_overcurrent,
  input  wire logic                  motor_overcurrent,
  input  wire logic                  transceiver_overcurrent,
  input  wire logic                  main_supply_overvoltage,
  input  wire logic                  logic_supply_overvoltage,
  input  wire logic                  logic_supply_undervoltage,
  input  wire logic                  pump_low_voltage,
  input  wire logic                  overtemperature,
  input  wire logic                  calibration_crc_error,
  input  wire logic                  watchdog_fail,
  input  wire logic                  clock_monitor_fail,
  input  wire logic                  overcurrent_detect_enable,
  input  wire logic                  predriver_control_enable,
  // settings and status outputs
  output logic                       sample_hold_select,
  output logic                       short_calibration_select,
  output fault_diag_pkg::gain_t      phase_gain,
  output logic                       predriver_enable,
  output logic                       fault_out_n,
  output logic                       cpu_reset_output,
  output logic                       motor_overcurrent_flag
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [14:0] s1_q;
  logic [14:0] s2_q;
  logic [14:0] raw;
  assign raw = {cs_n, sck, din, supply_overcurrent, motor_overcurrent,
                transceiver_overcurrent, main_supply_overvoltage,
                logic_supply_overvoltage, logic_supply_undervoltage,
                pump_low_voltage, overtemperature, calibration_crc_error,
                watchdog_fail, clock_monitor_fail, overcurrent_detect_enable};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 15'h4000 | 15'h2000;
      s2_q <= 15'h4000 | 15'h2000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic cs_s, sck_s, din_s, sup_oc, mot_oc, xc_oc, main_ov, log_ov, log_uv;
  logic pump_lv, otemp, crc_err, wd_s, cm_s, oc_en;
  assign {cs_s, sck_s, din_s, sup_oc, mot_oc, xc_oc, main_ov, log_ov, log_uv,
          pump_lv, otemp, crc_err, wd_s, cm_s, oc_en} = s2_q;
  logic wd_fail;
  assign wd_fail = wd_s | cm_s;

  logic cs_prev_q;
  logic sck_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b1;
    end else begin
      cs_prev_q  <= cs_s;
      sck_prev_q <= sck_s;
    end
  end
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall  = cs_prev_q & ~cs_s;
  assign cs_rise  = ~cs_prev_q & cs_s;
  assign sck_rise = ~cs_s & ~sck_prev_q & sck_s;
  assign sck_fall = ~cs_s & sck_prev_q & ~sck_s;

  // ----------------------------------------
  // receive shift and bit count
  // ----------------------------------------
  logic [15:0] rx_q;
  logic [5:0]  cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_q  <= 16'h0000;
      cnt_q <= 6'h00;
    end else if (cs_fall) begin
      cnt_q <= 6'h00;
    end else if (sck_rise) begin
      rx_q  <= {rx_q[14:0], din_s};
      if (cnt_q != 6'h3F) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
  logic       frame_ok;
  logic [5:0] cmd;
  assign frame_ok = (cnt_q == {1'b0, `FRAME_BITS});
  assign cmd      = rx_q[`CMD_MSB:`CMD_LSB];
  logic cmd_known;
  always_comb begin
    unique case (cmd)
      `CMD_MODE_SET, `CMD_GAIN_SET, `CMD_SPARE_SET,
      `CMD_FIRST_DIAG, `CMD_SECOND_DIAG, `CMD_THIRD_DIAG: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  end
  logic frame_done;
  assign frame_done = cs_rise & frame_ok;
  logic frame_err_evt;
  assign frame_err_evt = cs_rise & (~frame_ok | ~cmd_known);

  // ----------------------------------------
  // setting registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_hold_select       <= 1'b0;
      short_calibration_select <= 1'b0;
    end else if (frame_done && cmd == `CMD_MODE_SET) begin
      sample_hold_select       <= rx_q[`FLD_HI];
      short_calibration_select <= rx_q[`FLD_LO];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_gain <= fault_diag_pkg::gain_t'(`GAIN_RESET);
    end else if (frame_done && cmd == `CMD_GAIN_SET) begin
      phase_gain <= fault_diag_pkg::gain_t'(rx_q[`FLD_HI:`FLD_LO]);
    end
  end

  // ----------------------------------------
  // motor overcurrent latch and driver stop
  // ----------------------------------------
  logic oc_set;
  assign oc_set = cpu_reset_output & oc_en & mot_oc;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motor_overcurrent_flag <= 1'b0;
    end else if (!cpu_reset_output || !oc_en) begin
      motor_overcurrent_flag <= 1'b0;
    end else if (oc_set) begin
      motor_overcurrent_flag <= 1'b1;
    end
  end
  logic stop;
  assign stop = oc_set | otemp | log_uv;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      predriver_enable <= 1'b0;
    end else begin
      predriver_enable <= cpu_reset_output & predriver_control_enable &
                          ~stop;
    end
  end

  // ----------------------------------------
  // diagnosis status and shadow registers
  // ----------------------------------------
  logic [7:0] evt1;
  assign evt1 = {sup_oc, oc_set, xc_oc, main_ov, log_ov, pump_lv, otemp, crc_err};
  logic [7:0] stat1_q, shad1_q, snap1_q;
  logic       stat2_q, shad2_q, snap2_q;
  logic       busy;
  assign busy = ~cs_s;
  logic [7:0] last_cmd_q;
  logic       rd1, rd2;
  logic [7:0] seen1;
  assign rd1   = frame_done & (last_cmd_q[5:0] == `CMD_FIRST_DIAG);
  assign rd2   = frame_done & (last_cmd_q[5:0] == `CMD_SECOND_DIAG);
  assign seen1 = rd1 ? snap1_q : 8'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat1_q <= 8'h00;
      shad1_q <= 8'h00;
      snap1_q <= 8'h00;
    end else if (cs_fall) begin
      snap1_q <= stat1_q;
      shad1_q <= evt1;
    end else if (busy) begin
      shad1_q <= shad1_q | evt1;
    end else if (cs_rise) begin
      stat1_q <= (stat1_q & ~seen1) | shad1_q | evt1;
      shad1_q <= 8'h00;
    end else begin
      stat1_q <= stat1_q | evt1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat2_q <= 1'b0;
      shad2_q <= 1'b0;
      snap2_q <= 1'b0;
    end else if (cs_fall) begin
      snap2_q <= stat2_q;
      shad2_q <= 1'b0;
    end else if (cs_rise) begin
      stat2_q <= (stat2_q & ~(rd2 & snap2_q)) | shad2_q | frame_err_evt;
      shad2_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // reply shifter
  // ----------------------------------------
  logic [15:0] tx_q;
  logic [15:0] reply;
  always_comb begin
    unique case (last_cmd_q[5:0])
      `CMD_FIRST_DIAG:  reply = {`HDR_FIRST_DIAG, snap1_q};
      `CMD_SECOND_DIAG: reply = {`HDR_SECOND_DIAG, snap2_q, 7'h00};
      `CMD_THIRD_DIAG:  reply = {`HDR_THIRD_DIAG, 8'h00};
      `CMD_MODE_SET:    reply = {`HDR_MODE_ECHO, sample_hold_select,
                                 short_calibration_select, 6'h00};
      `CMD_GAIN_SET:    reply = {`HDR_GAIN_ECHO, phase_gain, 6'h00};
      default:          reply = {`HDR_IDLE, 8'h00};
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_cmd_q <= 8'h00;
    end else if (frame_done && cmd_known) begin
      last_cmd_q <= {2'h0, cmd};
    end
  end
  logic tx_load_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= cs_fall;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
    end else if (tx_load_q) begin
      tx_q <= reply;
    end else if (sck_fall && cnt_q != 6'h00) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout    <= tx_load_q ? reply[15] : tx_q[15];
      dout_oe <= ~cs_s;
    end
  end

  // ----------------------------------------
  // fault and reset outputs
  // ----------------------------------------
  logic fault_low;
  assign fault_low = log_ov | crc_err | xc_oc | main_ov | pump_lv | log_uv | wd_fail
                   | stat2_q | (|stat1_q[`BIT_LOGIC_OV:`BIT_PUMP_LV])
                   | stat1_q[`BIT_CAL_CRC] | stat1_q[`BIT_XCVR_CUR]
                   | stat1_q[`BIT_MAIN_OV];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_out_n      <= 1'b0;
      cpu_reset_output <= 1'b0;
    end else begin
      fault_out_n      <= ~fault_low;
      cpu_reset_output <= ~(log_uv | wd_fail);
    end
  end
endmodule

// *** rtl/fault_diag_params.svh ***
// constants for the serial command and diagnosis logic
`ifndef FAULT_DIAG_PARAMS_SVH
`define FAULT_DIAG_PARAMS_SVH
`define FRAME_BITS        5'd16
`define CMD_MSB           15
`define CMD_LSB           10
`define CMD_MODE_SET      6'h01
`define CMD_GAIN_SET      6'h02
`define CMD_SPARE_SET     6'h03
`define CMD_FIRST_DIAG    6'h08
`define CMD_SECOND_DIAG   6'h10
`define CMD_THIRD_DIAG    6'h18
`define FLD_HI            7
`define FLD_LO            6
`define HDR_IDLE          8'h02
`define HDR_MODE_ECHO     8'h04
`define HDR_GAIN_ECHO     8'h06
`define HDR_FIRST_DIAG    8'h10
`define HDR_SECOND_DIAG   8'h20
`define HDR_THIRD_DIAG    8'h30
`define BIT_SUPPLY_CUR    7
`define BIT_OVERCUR       6
`define BIT_XCVR_CUR      5
`define BIT_MAIN_OV       4
`define BIT_LOGIC_OV      3
`define BIT_PUMP_LV       2
`define BIT_OVERTEMP      1
`define BIT_CAL_CRC       0
`define GAIN_RESET        2'h0
`endif

// *** rtl/fault_diag_pkg.sv ***
// types for the serial command and diagnosis logic
package fault_diag_pkg;
  typedef enum logic [1:0] {
    GAIN_X1 = 2'h0,
    GAIN_X2 = 2'h1,
    GAIN_X3 = 2'h2,
    GAIN_X4 = 2'h3
  } gain_t;
endpackage

// *** testbench/spi_fault_diag_props.sv ***
// assertions on the serial command and diagnosis ports
`timescale 1ns/1ns
module spi_fault_diag_checker (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // inputs watched
  input wire logic                  cs_n,
  input wire logic                  motor_overcurrent,
  input wire logic                  logic_supply_overvoltage,
  input wire logic                  logic_supply_undervoltage,
  input wire logic                  overtemperature,
  input wire logic                  watchdog_fail,
  input wire logic                  overcurrent_detect_enable,
  // outputs watched
  input wire fault_diag_pkg::gain_t phase_gain,
  input wire logic                  predriver_enable,
  input wire logic                  fault_out_n,
  input wire logic                  cpu_reset_output,
  input wire logic                  motor_overcurrent_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_oc_live;
    overcurrent_detect_enable && motor_overcurrent && cpu_reset_output;
  endsequence
  property p_uv;
    logic_supply_undervoltage [*6] |-> !cpu_reset_output && !fault_out_n && !predriver_enable;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage outputs wrong");
  property p_wd;
    watchdog_fail [*6] |-> !cpu_reset_output && !fault_out_n;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog outputs wrong");
  property p_rst;
    !cpu_reset_output [*3] |-> !motor_overcurrent_flag && !predriver_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset low state wrong");
  property p_ocd;
    !overcurrent_detect_enable [*6] |-> !motor_overcurrent_flag;
  endproperty
  a_ocd: assert property (p_ocd) else $error("flag set while detect off");
  property p_oc;
    s_oc_live [*6] |-> motor_overcurrent_flag && !predriver_enable && fault_out_n;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent latch wrong");
  property p_ot;
    overtemperature [*6] |-> !predriver_enable;
  endproperty
  a_ot: assert property (p_ot) else $error("overtemperature no stop");
  property p_ov;
    logic_supply_overvoltage [*6] |-> !fault_out_n && cpu_reset_output;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage outputs wrong");
  property p_hold;
    cs_n [*8] |-> $stable(phase_gain);
  endproperty
  a_hold: assert property (p_hold) else $error("gain moved outside frame");
endmodule
bind spi_fault_diag_command_logic spi_fault_diag_checker spi_fault_diag_checker_i (
  .clk, .rst_n, .cs_n, .motor_overcurrent, .logic_supply_overvoltage,
  .logic_supply_undervoltage, .overtemperature, .watchdog_fail,
  .overcurrent_detect_enable, .phase_gain, .predriver_enable, .fault_out_n,
  .cpu_reset_output, .motor_overcurrent_flag);

// *** testbench/mcu.sv ***
// serial port master model
`timescale 1ns/1ns
module mcu (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    din = 1'b1;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q);
    q = 16'h0000;
    tick(1);
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      din = d[15-i];
      tick(4);
      sck = 1'b1;
      tick(3);
      q = {q[14:0], dout};
      tick(1);
    end
    cs_n = 1'b1;
    din = 1'b1;
    tick(8);
  endtask
endmodule

// *** testbench/test_spi_fault_diag_command_logic.sv ***
// self-checking bench for the serial command and diagnosis logic
`timescale 1ns/1ns
`include "fault_diag_params.svh"
module test_spi_fault_diag_command_logic;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sck, din, dout;
  logic [10:0] flt = 11'h000;
  logic        overcurrent_fail_flag = 1'b1;
  logic        ctl = 1'b1;
  logic        sh, sc, pen, fn, rs, mf, oe;
  logic [15:0] r;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [11:0] tbl [11] = '{12'hE80, 12'h740, 12'hA20, 12'hA10, 12'hA08, 12'h000,
                            12'hA04, 12'h602, 12'hA01, 12'h000, 12'h000};
  fault_diag_pkg::gain_t gain;
  always #5 clk = ~clk;
  mcu mcu_i (.clk, .cs_n, .sck, .din, .dout);
  spi_fault_diag_command_logic spi_fault_diag_command_logic_i (
    .clk, .rst_n, .cs_n, .sck, .din, .dout, .dout_oe(oe),
    .supply_overcurrent(flt[0]), .motor_overcurrent(flt[1]),
    .transceiver_overcurrent(flt[2]), .main_supply_overvoltage(flt[3]),
    .logic_supply_overvoltage(flt[4]), .logic_supply_undervoltage(flt[5]),
    .pump_low_voltage(flt[6]), .overtemperature(flt[7]), .calibration_crc_error(flt[8]),
    .watchdog_fail(flt[9]), .clock_monitor_fail(flt[10]),
    .overcurrent_detect_enable(overcurrent_fail_flag), .predriver_control_enable(ctl),
    .sample_hold_select(sh), .short_calibration_select(sc), .phase_gain(gain),
    .predriver_enable(pen), .fault_out_n(fn), .cpu_reset_output(rs),
    .motor_overcurrent_flag(mf));
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tx(input int n, input logic [15:0] d);
    mcu_i.xfer(n, d, r);
  endtask
  task automatic rd(input logic [5:0] c, input logic [15:0] e);
    tx(16, {c, 10'h000});
    tx(16, {`CMD_THIRD_DIAG, 10'h000});
    chk("reply", e, r);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    test_done();
  end
  initial begin
    step(3);
    rst_n = 1'b1;
    step(4);
    chk("defaults", 16'h0000, {12'h000, sh, sc, gain});
    chk("oe idle", 16'h0000, oe);
    tx(16, {`CMD_FIRST_DIAG, 10'h000});
    chk("idle", {`HDR_IDLE, 8'h00}, r);
    for (int i = 0; i < 4; i++) begin
      tx(16, {`CMD_MODE_SET, 2'b11, i[1:0], 6'h3F});
      tx(16, {`CMD_GAIN_SET, 2'b11, i[1:0], 6'h3F});
      chk("echo", {`HDR_MODE_ECHO, i[1:0], 6'h00}, r);
      chk("settings", {12'h000, i[1:0], i[1:0]}, {12'h000, sh, sc, gain});
    end
    $display("test settings done");
    tx(16, {`CMD_SPARE_SET, 10'h000});
    chk("gain echo", {`HDR_GAIN_ECHO, 2'b11, 6'h00}, r);
    tx(16, {`CMD_THIRD_DIAG, 10'h000});
    rd(`CMD_SECOND_DIAG, {`HDR_SECOND_DIAG, 8'h00});
    tx(16, 16'hFC00);
    chk("fault", 16'h0000, fn);
    rd(`CMD_SECOND_DIAG, {`HDR_SECOND_DIAG, 8'h80});
    rd(`CMD_SECOND_DIAG, {`HDR_SECOND_DIAG, 8'h00});
    chk("fault", 16'h0001, fn);
    tx(15, 16'h0400);
    rd(`CMD_SECOND_DIAG, {`HDR_SECOND_DIAG, 8'h80});
    chk("settings", 16'h000F, {12'h000, sh, sc, gain});
    $display("test commands done");
    for (int k = 0; k < 11; k++) begin
      flt[k] = 1'b1;
      step(8);
      chk("outputs", {12'h000, tbl[k][11:8]}, {12'h000, pen, fn, rs, mf});
      flt[k] = 1'b0;
      step(8);
      chk("held", {15'h0000, tbl[k][10] | ~|tbl[k][7:0]}, fn);
      rd(`CMD_FIRST_DIAG, {`HDR_FIRST_DIAG, tbl[k][7:0]});
      chk("after", {13'h0000, 2'b11, tbl[k][8]}, {13'h0000, pen, fn, mf});
      overcurrent_fail_flag = 1'b0;
      step(8);
      chk("cleared", 16'h0000, mf);
      overcurrent_fail_flag = 1'b1;
    end
    $display("test faults done");
    tx(16, {`CMD_FIRST_DIAG, 10'h000});
    fork
      tx(16, {`CMD_FIRST_DIAG, 10'h000});
      begin
        step(40);
        chk("oe", 16'h0001, oe);
        flt[0] = 1'b1;
        step(8);
        flt[0] = 1'b0;
      end
    join
    chk("snapshot", {`HDR_FIRST_DIAG, 8'h00}, r);
    tx(16, {`CMD_FIRST_DIAG, 10'h000});
    chk("shadow", {`HDR_FIRST_DIAG, 8'h80}, r);
    tx(16, {`CMD_SECOND_DIAG, 10'h000});
    chk("cleared", {`HDR_FIRST_DIAG, 8'h00}, r);
    $display("test shadow done");
    overcurrent_fail_flag = 1'b0;
    flt[1] = 1'b1;
    step(8);
    chk("masked", 16'h0002, {14'h0000, pen, mf});
    ctl = 1'b0;
    step(2);
    chk("ctl off", 16'h0000, pen);
    ctl = 1'b1;
    flt[1] = 1'b0;
    $display("test masked done");
    test_done();
  end
endmodule
